// ### hdl/timer_load_capture_control.v
// Timer load, capture and control registers with the two timers they steer
`timescale 1ns/1ps
module timer_load_capture_control (
    input  wire        clk,                    // System clock, 10 MHz
    input  wire        reset_n,                // Synchronous reset, active low
    input  wire [3:0]  address,                // Register address
    input  wire [7:0]  write_data,             // Register write data
    input  wire        write_strobe,           // One-cycle write strobe
    input  wire        read_strobe,            // One-cycle read strobe
    output reg  [7:0]  read_data,              // Read data, cycle after strobe
    input  wire        demod_mode,             // High selects demodulation mode
    input  wire        capture_pin,            // Asynchronous edge input
    input  wire [15:0] wide_timer_load_value,  // Reload value for the wide timer
    input  wire        narrow_timer_run,       // Narrow timer enable
    input  wire        gpio_out,               // Port data when pin is plain I/O
    input  wire        gpio_oe,                // Port enable when pin is plain I/O
    output reg         timer_pin_out,          // Pin output level
    output reg         timer_pin_oe,           // Pin output enable, high drives
    output reg         narrow_timer_output,    // Narrow timer waveform
    output reg         irq                     // Level interrupt request
);
`include "timer_load_capture_consts.vh"

    // Register storage
    reg  [7:0]  high_duration_q;
    reg  [7:0]  low_duration_q;
    reg         run_q;
    reg         mode_q;
    reg         timeout_q;
    reg  [1:0]  presc_q;
    reg         cap_mask_q;
    reg         to_mask_q;
    reg         pin_sel_q;
    reg  [7:0]  capture_high_q;
    reg  [7:0]  capture_low_q;
    reg  [1:0]  irq_status_q;
    reg  [1:0]  irq_enable_q;

    // Timer state
    reg  [15:0] wide_count_q;
    reg         wide_out_q;
    reg  [7:0]  narrow_count_q;
    reg         narrow_phase_q;

    // Capture input synchroniser
    reg         sync1_q;
    reg         sync2_q;
    reg         sync3_q;
    reg         pin_level_q;

    // Decoded accesses
    wire        wr_ctrl;
    wire        wr_high;
    wire        wr_low;
    wire        wr_enable;
    wire        wr_clear;
    wire        tick;
    wire        terminal;
    wire        pin_change;
    wire        capture_event;
    wire [7:0]  ctrl_view;
    reg  [7:0]  rd_d;

    // Timer helpers
    wire        count_tick;
    wire        count_zero;
    wire        start_load;
    wire        flag_clear;

    // Interrupt helpers and next values
    wire        clr_capture;
    wire        clr_timeout;
    reg  [1:0]  irq_status_d;
    reg         irq_d;
    reg         pin_out_d;
    reg         pin_oe_d;

    // One write enable per register
    assign wr_ctrl   = write_strobe && (address == `OFS_WIDE_CONTROL);
    assign wr_high   = write_strobe && (address == `OFS_NARROW_HIGH);
    assign wr_low    = write_strobe && (address == `OFS_NARROW_LOW);
    assign wr_enable = write_strobe && (address == `OFS_IRQ_ENABLE);
    assign wr_clear  = write_strobe && (address == `OFS_IRQ_CLEAR);

    // Control byte as software sees it
    assign ctrl_view = {run_q, mode_q, timeout_q, presc_q, cap_mask_q, to_mask_q, pin_sel_q};

    // Count tick from the selected system clock division
    wide_timer_prescaler #(
        .WIDTH (3)
    ) u_prescaler (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (run_q),
        .select  (presc_q),
        .tick    (tick)
    );

    // Ticks only count while running; zero is the terminal count
    assign count_tick = tick && run_q;
    assign count_zero = (wide_count_q == `RST_WORD);

    // Starting a stopped timer loads the count; writing 1 to bit 5 clears the flag
    assign start_load = wr_ctrl && write_data[`CTL_RUN_BIT] && !run_q; // RQ3
    assign flag_clear = wr_ctrl && write_data[`CTL_TIMEOUT_BIT];       // RQ11

    // Terminal count on a tick while counting in transmit mode
    assign terminal = count_tick && count_zero && !demod_mode; // RQ11

    // Edge recognised only in demodulation mode with the ignore bit clear
    assign capture_event = pin_change && run_q && demod_mode && !mode_q; // RQ4

    // Three-flop synchroniser; a change counts once the second and third agree
    always @(posedge clk) begin
        if (!reset_n) begin
            sync1_q     <= 1'b0;
            sync2_q     <= 1'b0;
            sync3_q     <= 1'b0;
            pin_level_q <= 1'b0;
        end else begin
            sync1_q <= capture_pin;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q == sync3_q) begin
                pin_level_q <= sync3_q;
            end
        end
    end

    // A settled level that differs from the last one is an edge, either direction
    assign pin_change = (sync2_q == sync3_q) && (sync3_q != pin_level_q);

    // Narrow timer duration registers
    always @(posedge clk) begin
        if (!reset_n) begin
            high_duration_q <= `RST_BYTE; // RQ1
            low_duration_q  <= `RST_BYTE; // RQ2
        end else begin
            if (wr_high) begin
                high_duration_q <= write_data; // RQ1
            end
            if (wr_low) begin
                low_duration_q <= write_data; // RQ2
            end
        end
    end

    // Static control fields
    always @(posedge clk) begin
        if (!reset_n) begin
            mode_q     <= 1'b0; // RQ10
            presc_q    <= `PRESC_DIV1;
            cap_mask_q <= 1'b0;
            to_mask_q  <= 1'b0;
            pin_sel_q  <= 1'b0;
        end else if (wr_ctrl) begin
            mode_q     <= write_data[`CTL_MODE_BIT]; // RQ4
            presc_q    <= write_data[`CTL_PRESC_HI:`CTL_PRESC_LO]; // RQ5
            cap_mask_q <= write_data[`CTL_CAP_MASK_BIT]; // RQ6
            to_mask_q  <= write_data[`CTL_TO_MASK_BIT]; // RQ7
            pin_sel_q  <= write_data[`CTL_PIN_SEL_BIT]; // RQ10
        end
    end

    // Run bit: software write wins; single pass ends itself at terminal count
    always @(posedge clk) begin
        if (!reset_n) begin
            run_q <= 1'b0;
        end else if (wr_ctrl) begin
            run_q <= write_data[`CTL_RUN_BIT]; // RQ3
        end else if (terminal && mode_q) begin
            run_q <= 1'b0; // RQ4
        end
    end

    // Time-out flag: terminal count sets it, writing 1 clears it, set wins
    always @(posedge clk) begin
        if (!reset_n) begin
            timeout_q <= 1'b0;
        end else if (terminal) begin
            timeout_q <= 1'b1; // RQ11
        end else if (flag_clear) begin
            timeout_q <= 1'b0; // RQ11
        end
    end

    // Wide counter: load on start, count down on ticks, reload or stop at zero
    always @(posedge clk) begin
        if (!reset_n) begin
            wide_count_q <= `RST_WORD;
            wide_out_q   <= 1'b0;
        end else if (start_load) begin
            wide_count_q <= wide_timer_load_value; // RQ3
            wide_out_q   <= 1'b0;
        end else if (capture_event) begin
            wide_count_q <= wide_timer_load_value;
        end else if (terminal) begin
            wide_out_q <= ~wide_out_q;
            if (!mode_q) begin
                wide_count_q <= wide_timer_load_value; // RQ4
            end
        end else if (count_tick && !count_zero) begin
            wide_count_q <= wide_count_q - 16'h0001;
        end
    end

    // Capture bytes take the count on a recognised edge; bus writes never reach them
    always @(posedge clk) begin
        if (!reset_n) begin
            capture_high_q <= `RST_BYTE; // RQ8
            capture_low_q  <= `RST_BYTE; // RQ9
        end else if (capture_event) begin
            capture_high_q <= wide_count_q[15:8]; // RQ8
            capture_low_q  <= wide_count_q[7:0];  // RQ9
        end
    end

    // Narrow timer: high for the high count plus one, low for the low count plus one, repeating
    always @(posedge clk) begin
        if (!reset_n) begin
            narrow_count_q      <= `RST_BYTE;
            narrow_phase_q      <= 1'b0;
            narrow_timer_output <= 1'b0;
        end else if (!narrow_timer_run) begin
            narrow_count_q      <= low_duration_q;
            narrow_phase_q      <= 1'b0;
            narrow_timer_output <= 1'b0;
        end else if (narrow_count_q == `RST_BYTE) begin
            narrow_phase_q      <= ~narrow_phase_q;
            narrow_timer_output <= ~narrow_phase_q;
            if (narrow_phase_q) begin
                narrow_count_q <= low_duration_q;  // RQ2
            end else begin
                narrow_count_q <= high_duration_q; // RQ1
            end
        end else begin
            narrow_count_q <= narrow_count_q - 8'h01;
        end
    end

    // Clear requests from the write-one-to-clear register
    assign clr_capture = wr_clear && write_data[`IRQ_CAPTURE_BIT];
    assign clr_timeout = wr_clear && write_data[`IRQ_TIMEOUT_BIT];

    // Next status: an event in the same cycle as its clear keeps the bit set
    always @* begin
        irq_status_d = irq_status_q;
        if (clr_capture) begin
            irq_status_d[`IRQ_CAPTURE_BIT] = 1'b0;
        end
        if (clr_timeout) begin
            irq_status_d[`IRQ_TIMEOUT_BIT] = 1'b0;
        end
        if (capture_event) begin
            irq_status_d[`IRQ_CAPTURE_BIT] = 1'b1; // RQ6
        end
        if (terminal) begin
            irq_status_d[`IRQ_TIMEOUT_BIT] = 1'b1; // RQ11
        end
    end

    // Interrupt status and enable registers
    always @(posedge clk) begin
        if (!reset_n) begin
            irq_status_q <= `RST_IRQ;
            irq_enable_q <= `RST_IRQ;
        end else begin
            irq_status_q <= irq_status_d;
            if (wr_enable) begin
                irq_enable_q <= write_data[1:0];
            end
        end
    end

    // Interrupt request: a set status bit that is both enabled and unmasked
    always @* begin
        irq_d = 1'b0;
        if (irq_status_q[`IRQ_CAPTURE_BIT] && irq_enable_q[`IRQ_CAPTURE_BIT] && cap_mask_q) begin
            irq_d = 1'b1; // RQ6
        end
        if (irq_status_q[`IRQ_TIMEOUT_BIT] && irq_enable_q[`IRQ_TIMEOUT_BIT] && to_mask_q) begin
            irq_d = 1'b1; // RQ7
        end
    end

    // Interrupt output registered so it comes straight from a flop
    always @(posedge clk) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_d;
        end
    end

    // Pin source: wide timer output when selected, plain port otherwise
    always @* begin
        if (pin_sel_q) begin
            pin_out_d = wide_out_q; // RQ10
            pin_oe_d  = 1'b1;       // RQ10
        end else begin
            pin_out_d = gpio_out;   // RQ10
            pin_oe_d  = gpio_oe;    // RQ10
        end
    end

    // Pin outputs registered
    always @(posedge clk) begin
        if (!reset_n) begin
            timer_pin_out <= 1'b0;
            timer_pin_oe  <= 1'b0;
        end else begin
            timer_pin_out <= pin_out_d;
            timer_pin_oe  <= pin_oe_d;
        end
    end

    // Read multiplexer; unmapped and write-only addresses read zero
    always @* begin
        case (address)
            `OFS_WIDE_CONTROL: rd_d = ctrl_view;       // RQ3
            `OFS_NARROW_LOW:   rd_d = low_duration_q;  // RQ2
            `OFS_NARROW_HIGH:  rd_d = high_duration_q; // RQ1
            `OFS_CAPTURE_LOW:  rd_d = capture_low_q;   // RQ9
            `OFS_CAPTURE_HIGH: rd_d = capture_high_q;  // RQ8
            `OFS_IRQ_STATUS:   rd_d = {6'h00, irq_status_q};
            `OFS_IRQ_ENABLE:   rd_d = {6'h00, irq_enable_q};
            default:           rd_d = `RST_BYTE;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (!reset_n) begin
            read_data <= `RST_BYTE;
        end else if (read_strobe) begin
            read_data <= rd_d;
        end else begin
            read_data <= `RST_BYTE;
        end
    end

endmodule // timer_load_capture_control

// ### hdl/timer_load_capture_consts.vh
// Constants for the timer load, capture and control register block
// Notes on behaviour
// [RQ1] High-duration register holds timer clocks the narrow output stays high; RW, resets zero. Code keeps it high for the value plus one.
// [RQ2] Low-duration register holds timer clocks the narrow output stays low; RW, resets zero. Code keeps it low for the value plus one.
// [RQ3] Control bit 7 write 1 starts, write 0 stops; read shows counting state.
// [RQ4] Bit 6: transmit 1 single pass, 0 modulo-n; demodulation 1 ignores, 0 recognises edges.
// [RQ5] Bits 4:3 pick wide timer clock: 11 /8, 10 /4, 01 /2, 00 undivided.
// [RQ6] Bit 2 set lets a capture event raise an interrupt request.
// [RQ7] Bit 1 set lets terminal count raise an interrupt request.
// [RQ8] High capture byte gets captured value MSB; read-only, writes ignored, resets zero.
// [RQ9] Low capture byte gets captured value LSB; read-only, writes ignored.
// [RQ10] Bit 0 set routes wide timer output to pin, else plain I/O; control resets zero.
// [RQ11] Bit 5 reads 1 after terminal count, cleared by writing 1.
`ifndef TIMER_LOAD_CAPTURE_CONSTS_VH
`define TIMER_LOAD_CAPTURE_CONSTS_VH

// Register offsets
`define OFS_WIDE_CONTROL      4'h2
`define OFS_NARROW_LOW        4'h4
`define OFS_NARROW_HIGH       4'h5
`define OFS_CAPTURE_LOW       4'h8
`define OFS_CAPTURE_HIGH      4'h9
`define OFS_IRQ_STATUS        4'hC
`define OFS_IRQ_ENABLE        4'hD
`define OFS_IRQ_CLEAR         4'hE

// Control register fields
`define CTL_RUN_BIT           7
`define CTL_MODE_BIT          6
`define CTL_TIMEOUT_BIT       5
`define CTL_PRESC_HI          4
`define CTL_PRESC_LO          3
`define CTL_CAP_MASK_BIT      2
`define CTL_TO_MASK_BIT       1
`define CTL_PIN_SEL_BIT       0

// Prescale codes
`define PRESC_DIV1            2'h0
`define PRESC_DIV2            2'h1
`define PRESC_DIV4            2'h2
`define PRESC_DIV8            2'h3

// Interrupt status fields
`define IRQ_CAPTURE_BIT       0
`define IRQ_TIMEOUT_BIT       1

// Reset values
`define RST_BYTE              8'h00
`define RST_WORD              16'h0000
`define RST_IRQ               2'h0

`endif

// ### hdl/wide_timer_prescaler.v
// Clock prescaler that produces the wide timer count tick
`timescale 1ns/1ps
module wide_timer_prescaler #(
    parameter WIDTH = 3                  // Divider counter width
) (
    input  wire       clk,               // System clock
    input  wire       reset_n,           // Synchronous reset, active low
    input  wire       run,               // Counting enabled
    input  wire [1:0] select,            // Division select
    output reg        tick               // One-cycle count tick
);
`include "timer_load_capture_consts.vh"

    reg  [WIDTH-1:0] div_q;
    reg  [WIDTH-1:0] limit;

    // Terminal value of the divider for each select code
    always @* begin
        case (select)
            `PRESC_DIV8: limit = 3'h7; // RQ5
            `PRESC_DIV4: limit = 3'h3; // RQ5
            `PRESC_DIV2: limit = 3'h1; // RQ5
            default:     limit = 3'h0; // RQ5
        endcase
    end

    // Divider restarts while stopped so the first tick comes a full period after start
    always @(posedge clk) begin
        if (!reset_n) begin
            div_q <= 3'h0;
            tick  <= 1'b0;
        end else if (!run) begin
            div_q <= 3'h0;
            tick  <= 1'b0;
        end else if (div_q >= limit) begin
            div_q <= 3'h0;
            tick  <= 1'b1;
        end else begin
            div_q <= div_q + 3'h1;
            tick  <= 1'b0;
        end
    end

endmodule // wide_timer_prescaler

// ### tb/timer_regs_assertions.sv
// Port checker for the timer load, capture and control block
`timescale 1ns/1ps
module timer_regs_check (
    input logic       clk,                 // Clock
    input logic       reset_n,             // Reset, active low
    input logic [3:0] address,             // Address
    input logic [7:0] write_data,          // Write data
    input logic       write_strobe,        // Write strobe
    input logic       read_strobe,         // Read strobe
    input logic [7:0] read_data,           // Read data
    input logic       gpio_out,            // Port data
    input logic       gpio_oe,             // Port enable
    input logic       narrow_timer_run,    // Narrow enable
    input logic       timer_pin_out,       // Pin level
    input logic       timer_pin_oe,        // Pin enable
    input logic       narrow_timer_output, // Narrow wave
    input logic       irq                  // Interrupt
);
    logic       sel_q;
    logic [7:0] hi_q;
    logic [8:0] cnt_q;

    // Shadow pin select and high duration, count cycles of a high phase
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sel_q <= 1'b0;
            hi_q  <= 8'h00;
            cnt_q <= 9'h000;
        end else begin
            if (write_strobe && address == 4'h2) begin
                sel_q <= write_data[0];
            end
            if (write_strobe && address == 4'h5) begin
                hi_q <= write_data;
            end
            cnt_q <= (narrow_timer_output && narrow_timer_run) ? cnt_q + 9'h001 : 9'h000;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Writes that must pull the interrupt down
    sequence en_off_s;
        write_strobe && address == 4'hD && write_data == 8'h00;
    endsequence
    sequence mask_off_s;
        write_strobe && address == 4'h2 && write_data[2:1] == 2'b00;
    endsequence

    rd_idle_a: assert property (!read_strobe |=> read_data == 8'h00)
        else $error("read data not zero when idle");
    rd_unmapped_a: assert property (read_strobe && !(address inside {4'h2, 4'h4, 4'h5, 4'h8, 4'h9, 4'hC, 4'hD})
        |=> read_data == 8'h00) else $error("unmapped read not zero");
    pin_gpio_a: assert property ($past(reset_n) && !$past(sel_q)
        |-> timer_pin_out == $past(gpio_out) && timer_pin_oe == $past(gpio_oe)) else $error("pin not plain port");
    pin_timer_a: assert property ($past(reset_n) && $past(sel_q) |-> timer_pin_oe)
        else $error("pin not driven by timer");
    narrow_off_a: assert property (!narrow_timer_run |=> !narrow_timer_output)
        else $error("narrow output high while stopped");
    narrow_high_a: assert property ($past(reset_n) && $fell(narrow_timer_output) && $past(narrow_timer_run)
        |-> cnt_q == {1'b0, hi_q} + 9'h001) else $error("high phase length wrong");
    irq_enable_a: assert property (en_off_s |-> ##2 !irq)
        else $error("interrupt high with enables off");
    irq_mask_a: assert property (mask_off_s |-> ##2 !irq)
        else $error("interrupt high with masks off");
endmodule // timer_regs_check

bind timer_load_capture_control timer_regs_check u_timer_regs_check (
    .clk(clk), .reset_n(reset_n), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .narrow_timer_run(narrow_timer_run),
    .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe),
    .narrow_timer_output(narrow_timer_output), .irq(irq));

// ### tb/tb.sv
// Self-checking bench for the timer load, capture and control block
`timescale 1ns/1ps
module tb;
    logic        clk;
    logic        reset_n;
    logic [3:0]  address;
    logic [7:0]  wdata;
    logic        wstb;
    logic        rstb;
    logic [7:0]  rdata;
    logic        demod;
    logic        cap_pin;
    logic [15:0] load;
    logic        nrun;
    logic        gpo;
    logic        gpe;
    logic        pin_out;
    logic        pin_oe;
    logic        nout;
    logic        irq;
    logic [7:0]  exp_q[$];
    logic        rd_pend;
    logic [31:0] seed;
    logic [31:0] gseed;
    logic [3:0]  ra [7] = '{4'h2, 4'h4, 4'h5, 4'h8, 4'h9, 4'hC, 4'hD};
    int          mismatches;
    int          compares;
    int          cycles;

    timer_load_capture_control u_timer_load_capture_control (
        .clk(clk), .reset_n(reset_n), .address(address), .write_data(wdata),
        .write_strobe(wstb), .read_strobe(rstb), .read_data(rdata), .demod_mode(demod),
        .capture_pin(cap_pin), .wide_timer_load_value(load), .narrow_timer_run(nrun),
        .gpio_out(gpo), .gpio_oe(gpe), .timer_pin_out(pin_out), .timer_pin_oe(pin_oe),
        .narrow_timer_output(nout), .irq(irq));

    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction

    task automatic end_sim();
        if (mismatches == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] read_data exp %h got %h", e, g);
        end
    endtask

    // Interrupt is looked at once the edge's updates have landed
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge clk);
        #1;
        compares++;
        if (irq !== e) begin
            mismatches++;
            $display("[ERR] irq exp %b got %b", e, irq);
        end
    endtask

    // Pin must carry the wide timer output and be driven
    task automatic chk_pin(input logic e);
        #1;
        compares++;
        if (pin_out !== e || pin_oe !== 1'b1) begin
            mismatches++;
            $display("[ERR] timer_pin_out exp %b got %b oe %b", e, pin_out, pin_oe);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        address <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge clk);
        wstb <= 1'b0;
    endtask

    // Read strobe, expected data noted for the watcher
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        address <= a;
        rstb <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rstb <= 1'b0;
    endtask

    // Watcher: read data stands in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_pend) begin
            chk_rd(exp_q.pop_front(), rdata);
        end
        rd_pend <= rstb && reset_n;
    end

    // Random port drive and hang limit
    always @(posedge clk) begin
        gseed = xs(gseed);
        gpo <= gseed[0];
        gpe <= gseed[1];
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    // Main sequence
    initial begin
        reset_n = 1'b0;
        address = 4'h0;
        wdata = 8'h00;
        wstb = 1'b0;
        rstb = 1'b0;
        demod = 1'b0;
        cap_pin = 1'b0;
        load = 16'h0003;
        nrun = 1'b0;
        gpo = 1'b0;
        gpe = 1'b0;
        rd_pend = 1'b0;
        seed = 32'h7838C858;
        gseed = 32'h7838C858;
        mismatches = 0;
        compares = 0;
        cycles = 0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        foreach (ra[i]) rd(ra[i], 8'h00);
        repeat (4) begin
            seed = xs(seed);
            wr(4'h4, seed[7:0]);
            wr(4'h5, seed[15:8]);
            wr(4'h2, seed[23:16] & 8'h5F);
            rd(4'h4, seed[7:0]);
            rd(4'h5, seed[15:8]);
            rd(4'h2, seed[23:16] & 8'h5F);
        end
        wr(4'h9, 8'hFF);
        wr(4'h8, 8'hFF);
        rd(4'h9, 8'h00);
        rd(4'h8, 8'h00);
        rd(4'h3, 8'h00);
        wr(4'h5, 8'h03);
        wr(4'h4, 8'h02);
        nrun <= 1'b1;
        repeat (40) @(posedge clk);
        nrun <= 1'b0;
        // Time-out per divided prescale setting (/2, /4, /8), modulo-n keeps running
        wr(4'hD, 8'h03);
        for (int p = 1; p < 4; p++) begin
            wr(4'h2, {3'b100, p[1:0], 3'b000});
            repeat ((4 << p) - 5) @(posedge clk);
            rd(4'h2, {3'b100, p[1:0], 3'b000});
            repeat (10) @(posedge clk);
            rd(4'h2, {3'b101, p[1:0], 3'b000});
            wr(4'h2, 8'h20);
        end
        rd(4'h2, 8'h00);
        rd(4'hC, 8'h02);
        wr(4'h2, 8'h02);
        chk_irq(1'b1);
        wr(4'h2, 8'h04);
        chk_irq(1'b0);
        wr(4'h2, 8'h02);
        wr(4'hD, 8'h00);
        chk_irq(1'b0);
        wr(4'hE, 8'h02);
        rd(4'hC, 8'h00);
        wr(4'h2, 8'hC1);
        repeat (20) @(posedge clk);
        rd(4'h2, 8'h61);
        chk_pin(1'b1);
        wr(4'h2, 8'h20);
        // Demodulation: ignored edge, then captured edge
        demod <= 1'b1;
        load <= 16'hAB80;
        wr(4'hD, 8'h01);
        wr(4'h2, 8'hDC);
        cap_pin <= 1'b1;
        repeat (10) @(posedge clk);
        rd(4'h9, 8'h00);
        rd(4'hC, 8'h02);
        wr(4'h2, 8'h9C);
        cap_pin <= 1'b0;
        repeat (10) @(posedge clk);
        rd(4'h9, 8'hAB);
        rd(4'hC, 8'h03);
        chk_irq(1'b1);
        wr(4'h9, 8'h00);
        rd(4'h9, 8'hAB);
        repeat (3) @(posedge clk);
        end_sim();
    end
endmodule // tb
